// ---- smc_top.sv ----
// Purpose: Control and status logic of the supply voltage monitor, AHB-Lite slave
// Assumes: Single clock hclk at 50 MHz, comparator output asynchronous
// Notes: Zero wait state bus; read data forwards a write in the same cycle
//
// Overview of operation
// - Three-bit threshold code 000..111 selects trip level 2.0V up to 4.0V
// - Read-only low supply flag, bit 5, is 1 while supply below trip
// - Monitor enable bit 4 turns detector on at 1, fully off at 0
// - Reference enable when detector (monitor bit set, not sleep), low-voltage reset or bit 3 enabled
// - Control bits 7 and 6 read zero and ignore writes
// - Sleep mode holds detector disabled even when monitor enabled
// - Comparator transitions reach low supply flag unfiltered
// - Interrupt request is one source of a shared multi-function interrupt
// - Hardware sets interrupt flag only after fixed delay following flag rise; software may set it any time
// - Set interrupt flag raises wake-up request out of sleep or idle
//
// Our own choices: the register addresses and the AHB-Lite register port.
module smc_top
#(
	parameter int CNT_W = smc_pkg::SMC_CNT_W,
	parameter int IRQ_DELAY_CYC = smc_pkg::SMC_IRQ_DELAY_CYC,
	parameter int SETTLE_CYC = smc_pkg::SMC_SETTLE_CYC
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire smc_pkg::smc_ahb_req_s ahb_req,
	output smc_pkg::smc_ahb_rsp_s ahb_rsp,
	input wire logic comparator_low,
	input wire logic sleep_mode,
	input wire logic idle_mode,
	input wire logic low_voltage_reset_function_en,
	output smc_pkg::smc_ana_s ana,
	output logic irq_request,
	output logic wake_request
);
	// ========================================
	// Address decode
	function automatic logic [2:0] reg_hit(input logic [11:0] addr);
		logic [2:0] hit;
		hit = 3'b000;
		hit[0] = (addr == smc_pkg::SMC_CTRL_OFS);
		hit[1] = (addr == smc_pkg::SMC_IRQ_OFS);
		hit[2] = (addr == smc_pkg::SMC_STAT_OFS);
		return hit;
	endfunction

	// ========================================
	// State and helpers
	smc_pkg::smc_top_st_s st_reg;
	smc_pkg::smc_top_st_s st_next;
	logic comp_sync;
	logic irq_done;
	logic settle_done;
	logic settle_run;
	logic addr_take;
	logic irq_rise;
	logic [2:0] wr_hit;
	logic [2:0] rd_hit;

	// ========================================
	// Comparator synchroniser
	smc_sync u_sync
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(comparator_low),
		.sync_out(comp_sync)
	);

	// ========================================
	// Settling and interrupt delay counters
	// Settling is reported only; the flag itself is never masked while settling
	assign settle_run = (st_reg.det != smc_pkg::SMC_DET_OFF);

	smc_delay #(.W(CNT_W), .COUNT(SETTLE_CYC)) u_settle
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.run(settle_run),
		.done(settle_done)
	);

	smc_delay #(.W(CNT_W), .COUNT(IRQ_DELAY_CYC)) u_irq_delay
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.run(st_reg.ctrl.low_supply_flag),
		.done(irq_done)
	);

	assign irq_rise = irq_done & ~st_reg.irq_done_q;
	assign addr_take = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
	assign wr_hit = reg_hit(st_reg.dph_addr);
	assign rd_hit = reg_hit(ahb_req.haddr[11:0]);

	// ========================================
	// Next state
	always_comb
	begin
		st_next = st_reg;
		st_next.irq_done_q = irq_done;

		// Write data phase; only the low five control bits are storable
		if (st_reg.dph_wr && wr_hit[0])
		begin
			st_next.ctrl.threshold_select = smc_pkg::smc_thr_e'(ahb_req.hwdata[2:0]);
			st_next.ctrl.reference_output_enable = ahb_req.hwdata[3];
			st_next.ctrl.monitor_enable_bit = ahb_req.hwdata[4];
		end
		st_next.ctrl.unused_hi = 2'b00;

		// Software may set or clear the flag; a hardware set in the same cycle wins
		if (st_reg.dph_wr && wr_hit[1])
			st_next.irq_flag = ahb_req.hwdata[smc_pkg::SMC_IRQ_FLAG_BIT];
		if (irq_rise)
			st_next.irq_flag = 1'b1;

		// Detector power state
		unique case (st_reg.det)
			smc_pkg::SMC_DET_OFF:
			begin
				if (st_reg.ctrl.monitor_enable_bit && !sleep_mode)
					st_next.det = smc_pkg::SMC_DET_SETTLE;
			end
			smc_pkg::SMC_DET_SETTLE:
			begin
				if (!st_reg.ctrl.monitor_enable_bit || sleep_mode)
					st_next.det = smc_pkg::SMC_DET_OFF;
				else if (settle_done)
					st_next.det = smc_pkg::SMC_DET_ON;
			end
			smc_pkg::SMC_DET_ON:
			begin
				if (!st_reg.ctrl.monitor_enable_bit || sleep_mode)
					st_next.det = smc_pkg::SMC_DET_OFF;
			end
			default:
				st_next.det = smc_pkg::SMC_DET_OFF;
		endcase

		// Raw comparator level, no debounce, so chatter near the trip is visible
		st_next.ctrl.low_supply_flag = (st_reg.det != smc_pkg::SMC_DET_OFF) & comp_sync;

		// Analog side controls
		st_next.ana.detector_enable = st_next.ctrl.monitor_enable_bit & ~sleep_mode;
		st_next.ana.reference_enable = st_next.ana.detector_enable
			| low_voltage_reset_function_en
			| st_next.ctrl.reference_output_enable;
		st_next.ana.threshold_select = st_next.ctrl.threshold_select;

		// Interrupt source and wake-up
		st_next.irq_req = st_next.irq_flag;
		st_next.wake_req = st_next.irq_flag;

		// Assertion helper: length of the current low run
		if (!st_reg.ctrl.low_supply_flag)
			st_next.low_len = 16'h0000;
		else if (st_reg.low_len != 16'hFFFF)
			st_next.low_len = st_reg.low_len + 16'h0001;

		// Address phase
		st_next.dph_wr = addr_take & ahb_req.hwrite;
		st_next.dph_addr = ahb_req.haddr[11:0];
		st_next.rsp.hreadyout = 1'b1;
		st_next.rsp.hresp = 1'b0;
		st_next.rsp.hrdata = smc_pkg::SMC_RDATA_RST;
		if (addr_take && !ahb_req.hwrite)
		begin
			if (rd_hit[0])
				st_next.rsp.hrdata = {24'h00_0000, st_next.ctrl};
			else if (rd_hit[1])
				st_next.rsp.hrdata = {31'h0000_0000, st_next.irq_flag};
			else if (rd_hit[2])
				st_next.rsp.hrdata = {30'h0000_0000,
					st_next.det == smc_pkg::SMC_DET_ON,
					st_next.det != smc_pkg::SMC_DET_OFF};
		end
	end

	// ========================================
	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_reg <= smc_pkg::SMC_ST_RST;
		else
			st_reg <= st_next;
	end

	// ========================================
	// Outputs
	assign ahb_rsp = st_reg.rsp;
	assign ana = st_reg.ana;
	assign irq_request = st_reg.irq_req;
	assign wake_request = st_reg.wake_req;

	// ========================================
	// Checks
	a_thr_write_lands: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(st_reg.dph_wr && wr_hit[0])
		|=> ana.threshold_select == $past(ahb_req.hwdata[2:0]))
		else $error("threshold code not applied after control write");

	a_low_tracks_comp: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(st_reg.det != smc_pkg::SMC_DET_OFF)
		|=> st_reg.ctrl.low_supply_flag == $past(comp_sync))
		else $error("low supply flag does not follow comparator");

	a_off_flag_low: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(!st_reg.ctrl.monitor_enable_bit) [*2]
		|-> !ana.detector_enable ##1 !st_reg.ctrl.low_supply_flag)
		else $error("detector active while monitor disabled");

	a_ref_enable_or: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) |-> ana.reference_enable == (ana.detector_enable
			|| st_reg.ctrl.reference_output_enable
			|| $past(low_voltage_reset_function_en)))
		else $error("reference enable mismatch");

	a_rsvd_read_zero: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ahb_rsp.hrdata[7:6] == 2'b00)
		else $error("unimplemented control bits read nonzero");

	a_sleep_holds_off: assert property (
		@(posedge hclk) disable iff (!hresetn)
		sleep_mode |=> !ana.detector_enable && st_reg.det == smc_pkg::SMC_DET_OFF)
		else $error("detector not held off in sleep");

	a_irq_out_flag: assert property (
		@(posedge hclk) disable iff (!hresetn)
		irq_request == st_reg.irq_flag)
		else $error("interrupt request differs from flag");

	a_irq_min_delay: assert property (
		@(posedge hclk) disable iff (!hresetn)
		irq_rise |-> st_reg.low_len >= 16'(IRQ_DELAY_CYC))
		else $error("interrupt flag set before delay elapsed");

	a_irq_set_wins: assert property (
		@(posedge hclk) disable iff (!hresetn)
		irq_rise |=> st_reg.irq_flag && irq_request)
		else $error("hardware set of interrupt flag lost");

	a_wake_follows: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$rose(st_reg.irq_flag) |-> wake_request)
		else $error("no wake-up request for set flag");

	a_sync_latency: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(st_reg.det == smc_pkg::SMC_DET_ON && $rose(comparator_low)) [*1]
		##1 (st_reg.det == smc_pkg::SMC_DET_ON && comparator_low) [*2]
		|=> st_reg.ctrl.low_supply_flag)
		else $error("comparator not seen after two-flop latency");

	a_bus_okay: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ahb_rsp.hreadyout && !ahb_rsp.hresp)
		else $error("slave stalled or signalled error");

	a_rdata_idle_zero: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!(addr_take && !ahb_req.hwrite) |=> ahb_rsp.hrdata == 32'h0000_0000)
		else $error("read data not zero outside a read");

	a_unused_bits_zero: assert property (
		@(posedge hclk) disable iff (!hresetn)
		st_reg.ctrl.unused_hi == 2'b00)
		else $error("unimplemented control bits stored nonzero");

	a_det_state_onehot: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$onehot(st_reg.det))
		else $error("detector state not one-hot");

	a_disabled_goes_off: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!st_reg.ctrl.monitor_enable_bit |=> st_reg.det == smc_pkg::SMC_DET_OFF)
		else $error("detector not off after enable cleared");

	a_det_enable_level: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$past(hresetn)
		|-> ana.detector_enable == (st_reg.ctrl.monitor_enable_bit && !$past(sleep_mode)))
		else $error("detector enable differs from enable bit and sleep");

	a_off_flag_zero: assert property (
		@(posedge hclk) disable iff (!hresetn)
		st_reg.det == smc_pkg::SMC_DET_OFF |=> !st_reg.ctrl.low_supply_flag)
		else $error("low supply flag set while detector off");

	a_flag_rise_comp: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$rose(st_reg.ctrl.low_supply_flag) |-> $past(comp_sync))
		else $error("low supply flag rose without comparator");

	a_flag_fall_comp: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$fell(st_reg.ctrl.low_supply_flag)
		|-> !$past(comp_sync) || $past(st_reg.det) == smc_pkg::SMC_DET_OFF)
		else $error("low supply flag fell while comparator low");

	a_irq_flag_holds: assert property (
		@(posedge hclk) disable iff (!hresetn)
		st_reg.irq_flag && !(st_reg.dph_wr && wr_hit[1])
		|=> st_reg.irq_flag)
		else $error("interrupt flag lost without software write");

	a_irq_no_spurious: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!st_reg.irq_flag && !irq_rise && !(st_reg.dph_wr && wr_hit[1])
		|=> !st_reg.irq_flag)
		else $error("interrupt flag set without cause");

	a_wake_equals_flag: assert property (
		@(posedge hclk) disable iff (!hresetn)
		wake_request == st_reg.irq_flag)
		else $error("wake-up request differs from flag");

	a_sw_irq_write: assert property (
		@(posedge hclk) disable iff (!hresetn)
		st_reg.dph_wr && wr_hit[1] && !irq_rise
		|=> st_reg.irq_flag == $past(ahb_req.hwdata[smc_pkg::SMC_IRQ_FLAG_BIT]))
		else $error("software write to interrupt flag not applied");

	a_sync_two_flops: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) && $past(hresetn, 2)
		|-> comp_sync == $past(comparator_low, 2))
		else $error("synchroniser latency is not two cycles");

	a_on_after_settle: assert property (
		@(posedge hclk) disable iff (!hresetn)
		st_reg.det == smc_pkg::SMC_DET_ON |-> settle_done)
		else $error("detector reported settled before settle count");
endmodule

// ---- smc_pkg.sv ----
// Purpose: Shared constants and types for the supply monitor control block
// Assumes: 50 MHz system clock, AHB-Lite word registers
// Notes: Offsets are byte addresses on the low address bits
package smc_pkg;
	// ========================================
	// Register map
	localparam int SMC_ADDR_W = 12;
	localparam logic [11:0] SMC_CTRL_OFS = 12'h000;
	localparam logic [11:0] SMC_IRQ_OFS = 12'h004;
	localparam logic [11:0] SMC_STAT_OFS = 12'h008;
	localparam int SMC_IRQ_FLAG_BIT = 0;
	localparam int SMC_STAT_ACTIVE_BIT = 0;
	localparam int SMC_STAT_SETTLED_BIT = 1;
	localparam logic [7:0] SMC_CTRL_RST = 8'h00;
	localparam logic [31:0] SMC_RDATA_RST = 32'h0000_0000;

	// ========================================
	// Timing
	localparam int SMC_CLK_PERIOD_NS = 20;
	localparam int SMC_IRQ_DELAY_NS = 15000;
	localparam int SMC_SETTLE_NS = 150000;
	localparam int SMC_IRQ_DELAY_CYC = (SMC_IRQ_DELAY_NS + SMC_CLK_PERIOD_NS - 1) / SMC_CLK_PERIOD_NS;
	localparam int SMC_SETTLE_CYC = (SMC_SETTLE_NS + SMC_CLK_PERIOD_NS - 1) / SMC_CLK_PERIOD_NS;
	localparam int SMC_CNT_W = 16;

	// ========================================
	// Types
	typedef enum logic [2:0] {
		SMC_THR_2V0 = 3'b000,
		SMC_THR_2V2 = 3'b001,
		SMC_THR_2V4 = 3'b010,
		SMC_THR_2V7 = 3'b011,
		SMC_THR_3V0 = 3'b100,
		SMC_THR_3V3 = 3'b101,
		SMC_THR_3V6 = 3'b110,
		SMC_THR_4V0 = 3'b111
	} smc_thr_e;

	typedef enum logic [2:0] {
		SMC_DET_OFF = 3'b001,
		SMC_DET_SETTLE = 3'b010,
		SMC_DET_ON = 3'b100
	} smc_det_e;

	typedef struct packed {
		logic [1:0] unused_hi;
		logic low_supply_flag;
		logic monitor_enable_bit;
		logic reference_output_enable;
		smc_thr_e threshold_select;
	} smc_ctrl_s;

	typedef struct packed {
		logic hsel;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] haddr;
		logic [31:0] hwdata;
		logic hready;
	} smc_ahb_req_s;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} smc_ahb_rsp_s;

	typedef struct packed {
		logic detector_enable;
		logic reference_enable;
		smc_thr_e threshold_select;
	} smc_ana_s;

	typedef struct packed {
		smc_ctrl_s ctrl;
		logic irq_flag;
		smc_det_e det;
		logic irq_done_q;
		logic dph_wr;
		logic [11:0] dph_addr;
		smc_ahb_rsp_s rsp;
		smc_ana_s ana;
		logic irq_req;
		logic wake_req;
		logic [15:0] low_len;
	} smc_top_st_s;

	localparam smc_top_st_s SMC_ST_RST = '{
		ctrl: SMC_CTRL_RST,
		irq_flag: 1'b0,
		det: SMC_DET_OFF,
		irq_done_q: 1'b0,
		dph_wr: 1'b0,
		dph_addr: 12'h000,
		rsp: '{hreadyout: 1'b1, hresp: 1'b0, hrdata: SMC_RDATA_RST},
		ana: '{detector_enable: 1'b0, reference_enable: 1'b0, threshold_select: SMC_THR_2V0},
		irq_req: 1'b0,
		wake_req: 1'b0,
		low_len: 16'h0000
	};
endpackage

// ---- smc_sync.sv ----
// Purpose: Two-flop synchroniser for the comparator level
// Assumes: Input may change at any time
// Notes: First stage feeds only the second
module smc_sync
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed {
		logic stage1;
		logic stage2;
	} smc_sync_st_s;

	smc_sync_st_s st_reg;
	smc_sync_st_s st_next;

	always_comb
	begin
		st_next.stage1 = async_in;
		st_next.stage2 = st_reg.stage1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_reg <= '{stage1: 1'b0, stage2: 1'b0};
		else
			st_reg <= st_next;
	end

	assign sync_out = st_reg.stage2;
endmodule

// ---- smc_delay.sv ----
// Purpose: Counts cycles while run stays high, then raises done
// Assumes: COUNT of at least one
// Notes: Any drop of run restarts the count from zero
module smc_delay
#(
	parameter int W = 16,
	parameter int COUNT = 750
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	output logic done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} smc_delay_st_s;

	smc_delay_st_s st_reg;
	smc_delay_st_s st_next;

	always_comb
	begin
		st_next = st_reg;
		if (!run)
		begin
			st_next.cnt = '0;
			st_next.done = 1'b0;
		end
		else if (st_reg.cnt == W'(COUNT - 1))
			st_next.done = 1'b1;
		else
			st_next.cnt = st_reg.cnt + W'(1);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_reg <= '{cnt: '0, done: 1'b0};
		else
			st_reg <= st_next;
	end

	assign done = st_reg.done;
endmodule

// ---- test_supply_voltage_monitor_ctrl.sv ----
// Purpose: Self-checking bench for the supply monitor control block
// Assumes: Zero wait state slave, short delay and settle counts
// Notes: Expected values come from a small integer model in the bench
module test_supply_voltage_monitor_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	// ========================================
	// Signals
	localparam int DLY = 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic comp = 1'b0;
	logic slp = 1'b0;
	logic idl = 1'b0;
	logic low_voltage_reset_function = 1'b0;
	logic h_sel = 1'b0;
	logic h_write = 1'b0;
	logic [1:0] h_trans = 2'b00;
	logic [31:0] h_addr = 32'h0000_0000;
	logic [31:0] h_wdata = 32'h0000_0000;
	smc_pkg::smc_ahb_req_s req;
	smc_pkg::smc_ahb_rsp_s rsp;
	smc_pkg::smc_ana_s ana;
	logic irq;
	logic wake;
	int fail_count = 0;
	int tests_run = 0;
	integer seed = 32'h11ba_38d1;
	integer ctrl_m;
	integer cnt;
	logic [31:0] rd;
	logic [31:0] d;
	// Bus hready is the single slave's own hreadyout
	assign req = '{hsel: h_sel, htrans: h_trans, hwrite: h_write, hsize: 3'b010,
		haddr: h_addr, hwdata: h_wdata, hready: rsp.hreadyout};
	smc_top #(.CNT_W(16), .IRQ_DELAY_CYC(DLY), .SETTLE_CYC(8)) smc_top_inst
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.ahb_req(req),
		.ahb_rsp(rsp),
		.comparator_low(comp),
		.sleep_mode(slp),
		.idle_mode(idl),
		.low_voltage_reset_function_en(low_voltage_reset_function),
		.ana(ana),
		.irq_request(irq),
		.wake_request(wake)
	);
	initial forever #10 hclk = ~hclk;
	// ========================================
	// Tasks
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Bounded wait for hready at a rising edge
	task automatic wait_rdy;
		int i;
		i = 0;
		@(posedge hclk);
		while (rsp.hreadyout !== 1'b1)
		begin
			i++;
			if (i > 50)
			begin
				fail_count++;
				conclude();
			end
			@(posedge hclk);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		h_sel <= 1'b1;
		h_trans <= 2'b10;
		h_write <= w;
		h_addr <= {20'h0_0000, a};
		wait_rdy();
		h_sel <= 1'b0;
		h_trans <= 2'b00;
		h_wdata <= wd;
		wait_rdy();
		rd = rsp.hrdata;
	endtask
	// ========================================
	// Sequence
	initial
	begin
		cyc(5);
		hresetn <= 1'b1;
		bus(1'b0, smc_pkg::SMC_CTRL_OFS, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		bus(1'b0, smc_pkg::SMC_IRQ_OFS, 32'h0000_0000);
		check({rd[7:0], ana, irq, wake}, 15'h0000);
		$display("test reset done");
		// Random upper bits must vanish; all eight codes and enable mixes
		for (int t = 0; t < 8; t++)
		begin
			d = $random(seed);
			d[2:0] = t[2:0];
			low_voltage_reset_function <= d[9];
			bus(1'b1, smc_pkg::SMC_CTRL_OFS, d);
			ctrl_m = d & 32'h0000_001f;
			bus(1'b0, smc_pkg::SMC_CTRL_OFS, 32'h0000_0000);
			check(rd, ctrl_m);
			check(ana.threshold_select, t[2:0]);
			check(ana.detector_enable, ctrl_m[4]);
			check(ana.reference_enable, ctrl_m[4] | ctrl_m[3] | d[9]);
		end
		$display("test control done");
		bus(1'b1, smc_pkg::SMC_CTRL_OFS, 32'h0000_0000);
		ctrl_m = 32'h0000_0015;
		bus(1'b1, smc_pkg::SMC_CTRL_OFS, ctrl_m);
		bus(1'b0, smc_pkg::SMC_STAT_OFS, 32'h0000_0000);
		check(rd, 32'h0000_0001);
		bus(1'b1, smc_pkg::SMC_IRQ_OFS, 32'h0000_0000);
		cyc(10);
		// Software waits for the settled bit before it trusts the flag
		bus(1'b0, smc_pkg::SMC_STAT_OFS, 32'h0000_0000);
		check(rd, 32'h0000_0003);
		// Low supply held: interrupt only after the fixed delay
		comp <= 1'b1;
		cnt = 0;
		while (irq !== 1'b1 && cnt < 100)
		begin
			@(posedge hclk);
			cnt++;
		end
		check(cnt >= DLY + 3 && cnt <= DLY + 6, 1'b1);
		check(wake, 1'b1);
		bus(1'b0, smc_pkg::SMC_IRQ_OFS, 32'h0000_0000);
		check(rd, 32'h0000_0001);
		comp <= 1'b0;
		cyc(6);
		bus(1'b1, smc_pkg::SMC_IRQ_OFS, 32'h0000_0000);
		cyc(1);
		check(irq, 1'b0);
		// A dip shorter than the delay must not set the flag
		comp <= 1'b1;
		cyc(2);
		comp <= 1'b0;
		cyc(12);
		check({irq, wake}, 2'b00);
		$display("test interrupt done");
		// Unfiltered toggling near the trip level
		for (int k = 0; k < 6; k++)
		begin
			comp <= ~k[0];
			cyc(4);
			bus(1'b0, smc_pkg::SMC_CTRL_OFS, 32'h0000_0000);
			check(rd, ctrl_m | ({31'h0, ~k[0]} << 5));
		end
		// Sleep forces the detector off and the flag low
		comp <= 1'b1;
		slp <= 1'b1;
		cyc(4);
		check(ana.detector_enable, 1'b0);
		bus(1'b0, smc_pkg::SMC_CTRL_OFS, 32'h0000_0000);
		check(rd, ctrl_m);
		bus(1'b0, smc_pkg::SMC_STAT_OFS, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		slp <= 1'b0;
		cyc(6);
		bus(1'b0, smc_pkg::SMC_CTRL_OFS, 32'h0000_0000);
		check(rd, 32'h0000_0035);
		bus(1'b1, smc_pkg::SMC_CTRL_OFS, 32'h0000_0005);
		cyc(4);
		bus(1'b0, smc_pkg::SMC_CTRL_OFS, 32'h0000_0000);
		check(rd, 32'h0000_0005);
		$display("test sleep done");
		// Software sets the flag while in idle
		comp <= 1'b0;
		idl <= 1'b1;
		bus(1'b1, smc_pkg::SMC_IRQ_OFS, 32'h0000_0001);
		cyc(1);
		check({irq, wake}, 2'b11);
		bus(1'b1, smc_pkg::SMC_IRQ_OFS, 32'h0000_0000);
		cyc(1);
		check(irq, 1'b0);
		idl <= 1'b0;
		// Unmapped place reads zero and keeps control intact
		bus(1'b1, 12'h00c, 32'hffff_ffff);
		bus(1'b0, 12'h00c, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		bus(1'b0, smc_pkg::SMC_CTRL_OFS, 32'h0000_0000);
		check(rd, 32'h0000_0005);
		// Reset in mid-run clears the control bits again
		bus(1'b1, smc_pkg::SMC_CTRL_OFS, 32'h0000_001f);
		hresetn <= 1'b0;
		cyc(2);
		hresetn <= 1'b1;
		bus(1'b0, smc_pkg::SMC_CTRL_OFS, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		$display("test misc done");
		conclude();
	end
	// Cuts a hang short
	initial
	begin
		repeat (20000) @(posedge hclk);
		fail_count++;
		conclude();
	end
endmodule
